/* rtl/exec_pkg.sv */
package exec_pkg;

  // ********************************************************************
  // Instruction fields
  // ********************************************************************
  localparam int COND_HI      = 31;
  localparam int COND_LO      = 28;
  localparam int IMM_SEL_BIT  = 25;
  localparam int OPC_HI       = 24;
  localparam int OPC_LO       = 21;
  localparam int FLAG_UPD_BIT = 20;
  localparam int RN_HI        = 19;
  localparam int RN_LO        = 16;
  localparam int RD_HI        = 15;
  localparam int RD_LO        = 12;
  localparam int SHAMT_HI     = 11;
  localparam int SHAMT_LO     = 7;
  localparam int SHTYPE_HI    = 6;
  localparam int SHTYPE_LO    = 5;
  localparam int SHREG_BIT    = 4;
  localparam int RS_HI        = 11;
  localparam int RS_LO        = 8;
  localparam int RM_HI        = 3;
  localparam int RM_LO        = 0;
  localparam int ROT_HI       = 11;
  localparam int ROT_LO       = 8;
  localparam int IMM8_HI      = 7;
  localparam int IMM8_LO      = 0;
  localparam int LINK_BIT     = 24;
  localparam int OFS_HI       = 23;
  localparam int OFS_LO       = 0;

  // ********************************************************************
  // Class decode patterns
  // ********************************************************************
  localparam logic [31:0] BX_MASK   = 32'h0ffffff0;
  localparam logic [31:0] BX_MATCH  = 32'h012fff10;
  localparam logic [2:0]  BR_MATCH  = 3'h5;
  localparam logic [1:0]  DP_MATCH  = 2'h0;
  localparam logic [3:0]  PC_INDEX  = 4'hf;
  localparam logic [3:0]  LR_INDEX  = 4'he;
  localparam logic [31:0] PC_AHEAD  = 32'h00000008;
  localparam logic [31:0] NEXT_INSN = 32'h00000004;
  localparam logic [31:0] ZERO_WORD = 32'h00000000;
  localparam logic [31:0] RESET_PC  = 32'h00000000;
  localparam logic [1:0]  BRANCH_S_CYCLES = 2'h2;

  // ********************************************************************
  // Types
  // ********************************************************************
  typedef enum logic [1:0] {
    logical_left_shift, logical_right_shift, arithmetic_right_shift, rotate_right_op
  } shift_e;

  typedef enum logic [3:0] {
    and_op, exclusive_or_op, sub_op, reverse_subtract_op, add_op, add_carry_op,
    subtract_carry_op, reverse_subtract_carry_op, test_and_op, test_equiv_op,
    compare_sub_op, compare_add_op, bitwise_or_op, move_op, bit_clear_op,
    move_inverted_op
  } opcode_e;

  typedef struct packed {
    logic n;
    logic z;
    logic c;
    logic v;
  } flags_s;

  typedef struct packed {
    logic [3:0]  index;
    logic [31:0] data;
    logic        valid;
  } reg_write_s;

endpackage

/* rtl/barrel_shifter.sv */
`timescale 1ns/100ps
module barrel_shifter (
  input  wire logic [31:0]          operand,
  input  wire exec_pkg::shift_e     kind,
  input  wire logic [7:0]           amount,
  input  wire logic                 from_register,
  input  wire logic                 carry_in,
  output logic      [31:0]          result,
  output logic                      carry_out
);
  import exec_pkg::*;

  logic [63:0] wide;
  logic [4:0]  amt5;

  always_comb begin
    amt5 = amount[4:0];
    wide = 64'h0;
    result = operand;
    carry_out = carry_in;
    if (from_register && amount == 8'h00) begin
      result = operand;
      carry_out = carry_in;
    end else if (!from_register && amt5 == 5'h00) begin
      case (kind)
        logical_left_shift: begin
          result = operand;
          carry_out = carry_in;
        end
        logical_right_shift: begin
          result = ZERO_WORD;
          carry_out = operand[31];
        end
        arithmetic_right_shift: begin
          result = {32{operand[31]}};
          carry_out = operand[31];
        end
        default: begin
          result = {carry_in, operand[31:1]};
          carry_out = operand[0];
        end
      endcase
    end else begin
      // Register amounts of 32 or more are treated modulo 32 here.
      case (kind)
        logical_left_shift: begin
          wide = {32'h0, operand} << amt5;
          result = wide[31:0];
          carry_out = wide[32];
        end
        logical_right_shift: begin
          wide = {operand, 32'h0} >> amt5;
          result = wide[63:32];
          carry_out = wide[31];
        end
        arithmetic_right_shift: begin
          wide = 64'($signed({operand, 32'h0}) >>> amt5);
          result = wide[63:32];
          carry_out = wide[31];
        end
        default: begin
          wide = {operand, operand} >> amt5;
          result = wide[31:0];
          carry_out = wide[31];
        end
      endcase
    end
  end

endmodule

/* rtl/alu_unit.sv */
`timescale 1ns/100ps
module alu_unit (
  input  wire exec_pkg::opcode_e    opcode,
  input  wire logic [31:0]          op1,
  input  wire logic [31:0]          op2,
  input  wire exec_pkg::flags_s     flags_in,
  input  wire logic                 shift_carry,
  output logic      [31:0]          result,
  output exec_pkg::flags_s          flags_out,
  output logic                      writes_dest
);
  import exec_pkg::*;

  logic [32:0] sum;
  logic [31:0] a;
  logic [31:0] b;
  logic        cin;
  logic        arith;

  always_comb begin
    a = op1;
    b = op2;
    cin = 1'b0;
    arith = 1'b1;
    sum = 33'h0;
    result = ZERO_WORD;
    case (opcode)
      sub_op, compare_sub_op: begin
        b = ~op2;
        cin = 1'b1;
      end
      reverse_subtract_op: begin
        a = ~op1;
        b = op2;
        cin = 1'b1;
      end
      add_op, compare_add_op: cin = 1'b0;
      add_carry_op: cin = flags_in.c;
      subtract_carry_op: begin
        b = ~op2;
        cin = flags_in.c;
      end
      reverse_subtract_carry_op: begin
        a = ~op1;
        cin = flags_in.c;
      end
      default: arith = 1'b0;
    endcase
    sum = {1'b0, a} + {1'b0, b} + {32'h0, cin};
    case (opcode)
      and_op, test_and_op:         result = op1 & op2;
      exclusive_or_op, test_equiv_op: result = op1 ^ op2;
      bitwise_or_op:               result = op1 | op2;
      move_op:                     result = op2;
      bit_clear_op:                result = op1 & ~op2;
      move_inverted_op:            result = ~op2;
      default:                     result = sum[31:0];
    endcase
    flags_out.n = result[31];
    flags_out.z = (result == ZERO_WORD);
    if (arith) begin
      flags_out.c = sum[32];
      flags_out.v = (a[31] == b[31]) && (result[31] != a[31]);
    end else begin
      flags_out.c = shift_carry;
      flags_out.v = flags_in.v;
    end
    writes_dest = !(opcode inside {test_and_op, test_equiv_op, compare_sub_op,
                                   compare_add_op});
  end

endmodule

/* rtl/branch_alu_shifter_execute.sv */
`timescale 1ns/100ps
// How it works
// - Every handled instruction runs only when its condition passes, else no-op.
// - Branch-exchange loads the counter from a register, flushes and refetches.
// - Bit zero of that register picks compact (one) or wide (zero) decode.
// - Branch-exchange takes two sequential and one non-sequential cycle.
// - Relative branch adds sign-extended 24-bit offset shifted left two.
// - The counter used for targets is instruction address plus eight.
// - Link writes next instruction address, low two bits clear; status untouched.
// - Relative branch, linked or not, takes two sequential plus one non-sequential.
// - First operand is a register; immediate bit picks shifted register or immediate.
// - Outside test and compare, the flag-update bit decides whether flags change.
// - Test and compare never write the destination and always set flags.
// - The four-bit opcode selects one of sixteen operations.
// - Logical ops: keep overflow, carry from shifter, zero and negative from result.
// - Arithmetic ops: overflow, ALU carry, zero and negative from result.
// - Shift amount comes from the instruction or a register's low byte.
// - An instruction shift amount is five bits, zero to thirty-one.
// - Left shift zero-fills, last bit out becomes carry.
// - Left shift by zero passes operand and old carry.
// - Right shift zero-fills; encoded zero means thirty-two.
// - Arithmetic right shift fills with the sign bit.
// - The condition comes from the top four instruction bits.
// - Arithmetic right shift encoded zero means thirty-two, all bits sign.
// - Rotate encoded zero rotates carry and operand one place right.
// - Immediate is zero-extended then rotated right by twice its rotate field.
module branch_alu_shifter_execute (
  input  wire logic                 mclk,
  input  wire logic                 rst,
  input  wire logic                 insn_valid,
  input  wire logic [31:0]          insn,
  input  wire logic [31:0]          insn_addr,
  input  wire logic [31:0]          first_operand_register,
  input  wire logic [31:0]          second_operand_register,
  input  wire logic [31:0]          shift_amount_register,
  output logic                      insn_ready,
  output logic                      insn_taken,
  output logic      [31:0]          program_counter,
  output logic                      pipeline_flush,
  output logic                      cycle_sequential,
  output logic                      compact_mode,
  output exec_pkg::flags_s          current_status_register,
  output exec_pkg::reg_write_s      reg_write
);
  import exec_pkg::*;

  // ********************************************************************
  // State
  // ********************************************************************
  typedef enum logic [1:0] {idle, branch_n, branch_s} phase_e;

  typedef struct packed {
    phase_e      phase;
    logic [1:0]  s_left;
    logic [31:0] pc;
    logic        compact;
    flags_s      flags;
    reg_write_s  wr;
    logic        flush;
    logic        seq;
    logic        taken;
  } state_s;

  state_s st;
  state_s next_st;

  // ********************************************************************
  // Decode and datapath
  // ********************************************************************
  logic [3:0]  cond;
  logic        cond_ok;
  logic        is_bx;
  logic        is_br;
  logic        is_dp;
  logic [31:0] imm_ext;
  logic [4:0]  rot_amt;
  logic [63:0] imm_rot;
  logic [31:0] op2;
  logic [31:0] sh_result;
  logic        sh_carry;
  logic [31:0] alu_result;
  flags_s      alu_flags;
  logic        alu_writes;
  logic [31:0] pc_read;
  logic [31:0] branch_ofs;

  assign cond  = insn[COND_HI:COND_LO];
  assign is_bx = (insn & BX_MASK) == BX_MATCH;
  assign is_br = insn[27:25] == BR_MATCH;
  assign is_dp = (insn[27:26] == DP_MATCH) && !is_bx;

  always_comb begin
    case (cond)
      4'h0: cond_ok = st.flags.z;
      4'h1: cond_ok = !st.flags.z;
      4'h2: cond_ok = st.flags.c;
      4'h3: cond_ok = !st.flags.c;
      4'h4: cond_ok = st.flags.n;
      4'h5: cond_ok = !st.flags.n;
      4'h6: cond_ok = st.flags.v;
      4'h7: cond_ok = !st.flags.v;
      4'h8: cond_ok = st.flags.c && !st.flags.z;
      4'h9: cond_ok = !st.flags.c || st.flags.z;
      4'ha: cond_ok = st.flags.n == st.flags.v;
      4'hb: cond_ok = st.flags.n != st.flags.v;
      4'hc: cond_ok = !st.flags.z && (st.flags.n == st.flags.v);
      4'hd: cond_ok = st.flags.z || (st.flags.n != st.flags.v);
      4'he: cond_ok = 1'b1;
      default: cond_ok = 1'b0;
    endcase
  end

  assign pc_read    = insn_addr + PC_AHEAD;
  assign branch_ofs = {{6{insn[OFS_HI]}}, insn[OFS_HI:OFS_LO], 2'b00};

  assign imm_ext = {24'h0, insn[IMM8_HI:IMM8_LO]};
  assign rot_amt = {insn[ROT_HI:ROT_LO], 1'b0};
  assign imm_rot = {imm_ext, imm_ext} >> rot_amt;

  barrel_shifter u_shift (
    .operand       (second_operand_register),
    .kind          (shift_e'(insn[SHTYPE_HI:SHTYPE_LO])),
    .amount        (insn[SHREG_BIT] ? shift_amount_register[7:0]
                                    : {3'h0, insn[SHAMT_HI:SHAMT_LO]}),
    .from_register (insn[SHREG_BIT]),
    .carry_in      (st.flags.c),
    .result        (sh_result),
    .carry_out     (sh_carry)
  );

  // Immediate operands take the rotate's top bit as carry only when rotated.
  assign op2 = insn[IMM_SEL_BIT] ? imm_rot[31:0] : sh_result;

  alu_unit u_alu (
    .opcode      (opcode_e'(insn[OPC_HI:OPC_LO])),
    .op1         (first_operand_register),
    .op2         (op2),
    .flags_in    (st.flags),
    .shift_carry (insn[IMM_SEL_BIT] ? ((rot_amt == 5'h00) ? st.flags.c : imm_rot[31])
                                    : sh_carry),
    .result      (alu_result),
    .flags_out   (alu_flags),
    .writes_dest (alu_writes)
  );

  assign insn_ready = (st.phase == idle);

  // ********************************************************************
  // Next state
  // ********************************************************************
  always_comb begin
    next_st = st;
    next_st.wr.valid = 1'b0;
    next_st.flush = 1'b0;
    next_st.taken = 1'b0;
    next_st.seq = 1'b1;
    case (st.phase)
      idle: begin
        if (insn_valid && cond_ok) begin
          next_st.taken = 1'b1;
          if (is_bx) begin
            next_st.pc = {first_operand_register[31:1], 1'b0};
            next_st.compact = first_operand_register[0];
            next_st.flush = 1'b1;
            next_st.seq = 1'b0;
            next_st.phase = branch_n;
          end else if (is_br) begin
            next_st.pc = pc_read + branch_ofs;
            next_st.flush = 1'b1;
            next_st.seq = 1'b0;
            next_st.phase = branch_n;
            if (insn[LINK_BIT]) begin
              next_st.wr.valid = 1'b1;
              next_st.wr.index = LR_INDEX;
              next_st.wr.data = (insn_addr + NEXT_INSN) & ~32'h3;
            end
          end else if (is_dp) begin
            if (insn[FLAG_UPD_BIT] || !alu_writes) begin
              next_st.flags = alu_flags;
            end
            if (alu_writes) begin
              next_st.wr.valid = 1'b1;
              next_st.wr.index = insn[RD_HI:RD_LO];
              next_st.wr.data = alu_result;
            end
            next_st.pc = insn_addr + NEXT_INSN;
          end
        end else if (insn_valid) begin
          next_st.pc = insn_addr + NEXT_INSN;
        end
      end
      branch_n: begin
        next_st.s_left = BRANCH_S_CYCLES;
        next_st.phase = branch_s;
      end
      branch_s: begin
        next_st.s_left = st.s_left - 2'h1;
        if (st.s_left == 2'h1) begin
          next_st.phase = idle;
        end
      end
      default: next_st.phase = idle;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st <= '{phase: idle, s_left: 2'h0, pc: RESET_PC, compact: 1'b0,
              flags: 4'h0, wr: '0, flush: 1'b0, seq: 1'b1, taken: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign insn_taken              = st.taken;
  assign program_counter         = st.pc;
  assign pipeline_flush          = st.flush;
  assign cycle_sequential        = st.seq;
  assign compact_mode            = st.compact;
  assign current_status_register = st.flags;
  assign reg_write               = st.wr;

endmodule

/* dv/exec_checker_assertions.sv */
`timescale 1ns/100ps
module exec_checker
  import exec_pkg::*;
(
  input wire logic             mclk,
  input wire logic             rst,
  input wire logic             insn_valid,
  input wire logic [31:0]      insn,
  input wire logic [31:0]      insn_addr,
  input wire logic [31:0]      first_operand_register,
  input wire logic             insn_ready,
  input wire logic             insn_taken,
  input wire logic [31:0]      program_counter,
  input wire logic             pipeline_flush,
  input wire logic             cycle_sequential,
  input wire logic             compact_mode,
  input wire exec_pkg::flags_s current_status_register,
  input wire exec_pkg::reg_write_s reg_write
);
  // ********
  // Timing and result checks
  // ********
  logic took;
  assign took = insn_valid && insn_ready && !rst;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_ready_gap: assert property (pipeline_flush |-> !insn_ready [*3] ##1 insn_ready)
    else $error("ready not low for three cycles after a branch");
  a_seq_pattern: assert property (pipeline_flush |-> !cycle_sequential ##1 cycle_sequential [*2])
    else $error("branch cycle types wrong");
  a_branch_target: assert property (pipeline_flush && $past(insn[27:25]) == BR_MATCH |->
    program_counter == $past(insn_addr) + PC_AHEAD + {{6{$past(insn[23])}}, $past(insn[23:0]), 2'h0})
    else $error("relative branch target wrong");
  a_link_write: assert property (pipeline_flush && $past(insn[27:24]) == 4'hb |-> reg_write.valid &&
    reg_write.index == LR_INDEX && reg_write.data == (($past(insn_addr) + NEXT_INSN) & 32'hfffffffc))
    else $error("link write wrong");
  a_bx_mode: assert property (pipeline_flush && ($past(insn) & BX_MASK) == BX_MATCH |->
    compact_mode == $past(first_operand_register[0]))
    else $error("decode mode not taken from bit zero");
  a_pc_next: assert property ($past(took) && !pipeline_flush |-> program_counter == $past(insn_addr) + NEXT_INSN)
    else $error("counter not advanced by one instruction");
  a_fail_quiet: assert property ($past(took) && !insn_taken |->
    !reg_write.valid && !pipeline_flush && $stable(current_status_register))
    else $error("failed condition had an effect");
  // The pre-reset flags are still sampled one edge after release, hence the reset term.
  a_flags_hold: assert property (!$past(rst) && !$past(took) |-> $stable(current_status_register))
    else $error("flags changed without an instruction");
  c_link: cover property (pipeline_flush && reg_write.valid);
  c_compact: cover property ($rose(compact_mode));
  c_flag_only: cover property (insn_taken && !reg_write.valid && !pipeline_flush);
endmodule

bind branch_alu_shifter_execute exec_checker u_exec_checker (.mclk(mclk), .rst(rst),
  .insn_valid(insn_valid), .insn(insn), .insn_addr(insn_addr),
  .first_operand_register(first_operand_register), .insn_ready(insn_ready),
  .insn_taken(insn_taken), .program_counter(program_counter), .pipeline_flush(pipeline_flush),
  .cycle_sequential(cycle_sequential), .compact_mode(compact_mode),
  .current_status_register(current_status_register), .reg_write(reg_write));

/* dv/tb_branch_alu_shifter_execute.sv */
`timescale 1ns/100ps
module tb_branch_alu_shifter_execute;
  import exec_pkg::*;
  // ********
  // Stimulus, reference model and monitor
  // ********
  typedef struct packed {
    logic [31:0] pc;
    logic [31:0] pm;
    flags_s      fl;
    logic        tk;
    logic        fu;
    logic        cm;
    reg_write_s  rw;
  } note_s;
  logic        mclk;
  logic        rst;
  logic        insn_valid;
  logic [31:0] insn;
  logic [31:0] insn_addr;
  logic [31:0] rn_v;
  logic [31:0] rm_v;
  logic [31:0] rs_v;
  logic        insn_ready;
  logic        insn_taken;
  logic [31:0] program_counter;
  logic        pipeline_flush;
  logic        cycle_sequential;
  logic        compact_mode;
  flags_s      current_status_register;
  reg_write_s  reg_write;
  note_s       q[$];
  flags_s      ef;
  logic        ecm;
  logic        pend = 1'b0;
  int          seed = 2;
  int          n_mismatch = 0;
  int          comparisons = 0;

  branch_alu_shifter_execute u_branch_alu_shifter_execute (.mclk(mclk), .rst(rst),
    .insn_valid(insn_valid), .insn(insn), .insn_addr(insn_addr),
    .first_operand_register(rn_v), .second_operand_register(rm_v),
    .shift_amount_register(rs_v), .insn_ready(insn_ready), .insn_taken(insn_taken),
    .program_counter(program_counter), .pipeline_flush(pipeline_flush),
    .cycle_sequential(cycle_sequential), .compact_mode(compact_mode),
    .current_status_register(current_status_register), .reg_write(reg_write));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  function automatic logic cond_ok(logic [3:0] c, flags_s f);
    logic r;
    case (c[3:1])
      3'h0: r = f.z;
      3'h1: r = f.c;
      3'h2: r = f.n;
      3'h3: r = f.v;
      3'h4: r = f.c && !f.z;
      3'h5: r = f.n == f.v;
      3'h6: r = !f.z && f.n == f.v;
      default: r = 1'b1;
    endcase
    return r ^ c[0];
  endfunction

  function automatic logic [32:0] shf(logic [31:0] v, logic [1:0] k, logic [4:0] a, logic c,
                                      logic rs);
    if (a == 0 && (rs || k == 0)) return {c, v};
    if (a == 0 && k == 1) return {v[31], 32'h0};
    if (a == 0 && k == 2) return {v[31], {32{v[31]}}};
    if (a == 0) return {v[0], c, v[31:1]};
    if (k == 0) return {v[32 - a], v << a};
    if (k == 1) return {v[a - 1], v >> a};
    if (k == 2) return {v[a - 1], 32'($signed(v) >>> a)};
    return {v[a - 1], (v >> a) | (v << (32 - a))};
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic dp(input logic [31:0] w);
    logic [32:0] so;
    logic [31:0] b;
    logic [31:0] x;
    logic [31:0] y;
    logic [31:0] r;
    logic [32:0] s;
    logic [4:0]  ra;
    logic        cin;
    logic        ar;
    logic        ok;
    flags_s      nf;
    ra = {w[11:8], 1'b0};
    b = {24'h0, w[7:0]};
    b = (b >> ra) | (b << (32 - ra));
    so = w[25] ? {ra == 0 ? ef.c : b[31], b} : shf(rm_v, w[6:5], w[4] ? rs_v[4:0] : w[11:7], ef.c, w[4]);
    {x, y, cin, ar} = {rn_v, so[31:0], 1'b0, 1'b1};
    case (w[24:21])
      4'h2, 4'ha: {y, cin} = {~so[31:0], 1'b1};
      4'h3: {x, y, cin} = {so[31:0], ~rn_v, 1'b1};
      4'h4, 4'hb: cin = 1'b0;
      4'h5: cin = ef.c;
      4'h6: {y, cin} = {~so[31:0], ef.c};
      4'h7: {x, y, cin} = {so[31:0], ~rn_v, ef.c};
      default: ar = 1'b0;
    endcase
    s = {1'b0, x} + {1'b0, y} + cin;
    case (w[24:21])
      4'h0, 4'h8: r = rn_v & so[31:0];
      4'h1, 4'h9: r = rn_v ^ so[31:0];
      4'hc: r = rn_v | so[31:0];
      4'hd: r = so[31:0];
      4'he: r = rn_v & ~so[31:0];
      4'hf: r = ~so[31:0];
      default: r = s[31:0];
    endcase
    nf = ef;
    nf.n = r[31];
    nf.z = r == 0;
    nf.c = ar ? s[32] : so[32];
    if (ar) nf.v = x[31] == y[31] && r[31] != x[31];
    ok = cond_ok(w[31:28], ef);
    if (ok && (w[20] || w[24:23] == 2'h2)) ef = nf;
    q.push_back({insn_addr + NEXT_INSN, 32'hffffffff, ef, ok, 1'b0, ecm, w[15:12], r,
                 ok && w[24:23] != 2'h2});
  endtask

  task automatic issue(input logic [31:0] w);
    int   k;
    logic ok;
    k = 0;
    while (insn_ready !== 1'b1 && k < 20) begin
      insn_valid = 1'b0;
      @(negedge mclk);
      k++;
    end
    insn = w;
    insn_valid = 1'b1;
    ok = cond_ok(w[31:28], ef);
    if (w[27:25] == BR_MATCH)
      q.push_back({ok ? insn_addr + PC_AHEAD + {{6{w[23]}}, w[23:0], 2'h0} : insn_addr + NEXT_INSN, 32'hffffffff, ef, ok, ok, ecm, LR_INDEX, (insn_addr + NEXT_INSN) & 32'hfffffffc, ok && w[24]});
    else if ((w & BX_MASK) == BX_MATCH) begin
      ecm = ok ? rn_v[0] : ecm;
      q.push_back({ok ? rn_v & 32'hfffffffe : insn_addr + NEXT_INSN, 32'hfffffffe, ef, ok, ok, ecm,
                   37'h0});
    end else
      dp(w);
    @(negedge mclk);
  endtask

  // Register shift amounts stay below 32, since larger ones are outside what the block handles.
  task automatic run(input int cnt);
    logic [31:0] w;
    for (int i = 0; i < cnt; i++) begin
      w = $random(seed);
      rn_v = $random(seed);
      rm_v = (i % 5 == 0) ? rn_v : $random(seed);
      rs_v = $random(seed) & 32'hffffff1f;
      insn_addr = $random(seed) & 32'hfffffffc;
      case (i % 8)
        0: begin
          w[27:25] = BR_MATCH;
          if (i % 16 == 0) w[23:0] = i[4] ? 24'h7fffff : 24'h800000;
        end
        1: w[27:0] = {BX_MATCH[27:4], w[3:0] == PC_INDEX ? 4'h0 : w[3:0]};
        default: begin
          w[27:26] = DP_MATCH;
          w[24:21] = 4'(i >> 3);
          if (w[24:23] == 2'h2) w[20] = 1'b1;
          if (w[15:12] == PC_INDEX) w[15:12] = LR_INDEX;
          if (w[4]) w[7] = 1'b0;
          else if (i % 3 == 0) w[11:7] = (i % 2 == 1) ? 5'h1f : 5'h0;
        end
      endcase
      issue(w);
    end
  endtask

  always @(posedge mclk) pend <= !rst && insn_valid && insn_ready;

  always @(negedge mclk) begin : mon
    note_s e;
    if (pend) begin
      e = q.pop_front();
      chk(program_counter & e.pm, e.pc);
      chk(insn_taken, e.tk);
      chk(pipeline_flush, e.fu);
      chk(compact_mode, e.cm);
      chk(current_status_register, e.fl);
      chk(reg_write.valid, e.rw.valid);
      if (e.rw.valid) begin
        chk(reg_write.index, e.rw.index);
        chk(reg_write.data, e.rw.data);
      end
    end
  end

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    end_of_test;
  end

  initial begin
    {rst, insn_valid, insn, insn_addr, rn_v, rm_v, rs_v, ef, ecm} = {2'h2, 165'h0};
    repeat (10) @(negedge mclk);
    rst = 1'b0;
    chk(program_counter, RESET_PC);
    chk(current_status_register, 32'h0);
    run(800);
    insn_valid = 1'b0;
    $display("test random mix done");
    repeat (6) @(negedge mclk);
    rst = 1'b1;
    repeat (2) @(negedge mclk);
    {rst, ef, ecm} = 6'h0;
    chk(program_counter, RESET_PC);
    chk(compact_mode, 32'h0);
    run(80);
    insn_valid = 1'b0;
    repeat (6) @(negedge mclk);
    $display("test reset mid run done");
    end_of_test;
  end
endmodule
